//--- inc/tstc_pkg.sv
package tstc_pkg;

	// clock and time bases, one decade apart
	localparam int CLK_PERIOD_NS = 100;
	localparam int TB0_NS        = 100;
	localparam int TB1_NS        = 1000;
	localparam int TB2_NS        = 10000;
	localparam int TB3_NS        = 100000;
	localparam int TB4_NS        = 1000000;
	localparam int TB0_CYC       = TB0_NS / CLK_PERIOD_NS;
	localparam int TB1_CYC       = TB1_NS / CLK_PERIOD_NS;
	localparam int TB2_CYC       = TB2_NS / CLK_PERIOD_NS;
	localparam int TB3_CYC       = TB3_NS / CLK_PERIOD_NS;
	localparam int TB4_CYC       = TB4_NS / CLK_PERIOD_NS;

	// widths
	localparam int DIV_W  = 14;
	localparam int CNT_W  = 16;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int SW_W   = 4;
	localparam int ST_W   = 2;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_SWITCH  = 4'h0;
	localparam logic [ADDR_W-1:0] REG_CONTROL = 4'h1;
	localparam logic [ADDR_W-1:0] REG_COUNT   = 4'h2;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 4'h3;
	localparam logic [ADDR_W-1:0] REG_MASK    = 4'h4;

	// field positions
	localparam int CTRL_CLEAR_BIT = 0;
	localparam int ST_OVF_BIT     = 0;
	localparam int ST_TRIG_BIT    = 1;

	// reset values
	localparam logic [SW_W-1:0]  SWITCH_RST = 4'h0;
	localparam logic [ST_W-1:0]  STATUS_RST = 2'h0;
	localparam logic [ST_W-1:0]  MASK_RST   = 2'h0;
	localparam logic [CNT_W-1:0] COUNT_RST  = 16'h0000;

	// switch settings
	localparam logic [SW_W-1:0] SW_RESET_HI = 4'h4;
	localparam logic [SW_W-1:0] SW_GATED_LO = 4'h5;
	localparam logic [SW_W-1:0] SW_GATED_HI = 4'h9;
	localparam logic [SW_W-1:0] SW_EVENT    = 4'hf;

	typedef enum logic [3:0] {
		TSTC_M_RESET = 4'b0001,
		TSTC_M_GATED = 4'b0010,
		TSTC_M_EVENT = 4'b0100,
		TSTC_M_IDLE  = 4'b1000
	} tstc_mode_t;

	function automatic tstc_mode_t tstc_mode(input logic [SW_W-1:0] sw);
		if (sw <= SW_RESET_HI)
			return TSTC_M_RESET;
		else if (sw <= SW_GATED_HI)
			return TSTC_M_GATED;
		else if (sw == SW_EVENT)
			return TSTC_M_EVENT;
		else
			return TSTC_M_IDLE;
	endfunction

	// decade of the time base, 0 fastest .. 4 slowest
	function automatic logic [2:0] tstc_decade(input logic [SW_W-1:0] sw);
		if (sw <= SW_RESET_HI)
			return sw[2:0];
		else if (sw <= SW_GATED_HI)
			return 3'(sw - SW_GATED_LO);
		else
			return 3'h0;
	endfunction

	function automatic logic [DIV_W-1:0] tstc_period(
		input logic [2:0]       dec,
		input logic [DIV_W-1:0] slow
	);
		case (dec)
			3'h0: return DIV_W'(TB0_CYC);
			3'h1: return DIV_W'(TB1_CYC);
			3'h2: return DIV_W'(TB2_CYC);
			3'h3: return DIV_W'(TB3_CYC);
			default: return slow;
		endcase
	endfunction

endpackage

//--- rtl/tstc_tick_div.sv
`timescale 1ns/1ps
module tstc_tick_div
	import tstc_pkg::*;
#(
	parameter logic [DIV_W-1:0] SLOW_CYC = DIV_W'(TB4_CYC)
)
(
	input  wire logic       ref_clk, // 10 MHz clock
	input  wire logic       rst,     // async reset, high
	input  wire logic       restart, // restart the period
	input  wire logic [2:0] decade,  // time base decade
	output logic            tick     // one-cycle time-base enable
);

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
	} tstc_div_state_t;

	tstc_div_state_t  st;
	tstc_div_state_t  next_st;
	logic [DIV_W-1:0] last;

	assign last = DIV_W'(tstc_period(decade, SLOW_CYC) - 1'b1);
	assign tick = (st.cnt == last); // R5 R14 R3

	always_comb
	begin
		next_st = st;
		if (restart || st.cnt >= last)
			next_st.cnt = '0;
		else
			next_st.cnt = DIV_W'(st.cnt + 1'b1);
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
			st <= '0;
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_fast_tick: assert property ( // R5
		decade == 3'h0 |-> tick)
		else $error("fastest base must tick every cycle");

	a_micro_tick: assert property ( // R14
		(tick && decade == 3'h1 && !restart)
		##1 (decade == 3'h1 && !restart)[*8]
		##1 !restart ##1 !restart
		|-> tick && !$past(tick, 1) && !$past(tick, 9))
		else $error("1 us base must tick every 10 cycles");

endmodule

//--- rtl/tstc_top.sv
// Overview of operation
// R1: settings 5-9 count ticks only while trigger is high, holding otherwise
// R2: settings 0-4 zero the count on trigger, otherwise count ticks freely
// R3: setting 9 gives the slowest of the gated time bases
// R4: counter wrap sets an overflow flag that lights the overflow lamp
// R5: setting 5 counts in 0.1 us units
// R6: two external trigger pins, one active low, one active high
// R7: the active-low external trigger counts as asserted when low
// R8: the active-high external trigger counts as asserted when high
// R9: external triggers act like the event trigger, two clock cycles later
// R10: count is a plain number of time-base units
// R11: current count is supplied with every trace cycle
// R12: user clears the counter before a gated measurement
// R13: setting F counts one per trigger rising edge, ignoring time base
// R14: setting 1 counts in 1 us units
// R15: combined trigger is OR of event trigger and both pins
// R16: pins are synchronised; manual reset also clears overflow
`timescale 1ns/1ps
module tstc_top
	import tstc_pkg::*;
#(
	parameter int unsigned SLOW_TICK_CYCLES = TB4_CYC
)
(
	input  wire logic              ref_clk,         // 10 MHz clock
	input  wire logic              rst,             // async reset, high
	input  wire logic [ADDR_W-1:0] reg_addr,        // register address
	input  wire logic [DATA_W-1:0] reg_wdata,       // write data
	input  wire logic              reg_wr,          // write strobe
	input  wire logic              reg_rd,          // read strobe
	output logic      [DATA_W-1:0] reg_rdata,       // read data, next cycle
	input  wire logic              event_trigger,   // event-match trigger
	input  wire logic              trigger_input_n, // pin, asserted low
	input  wire logic              trigger_input,   // pin, asserted high
	input  wire logic              manual_reset,    // button pin, high
	output logic      [CNT_W-1:0]  stamp_count,     // count for trace
	output logic                   overflow_lamp,   // overflow indicator
	output logic                   irq              // interrupt level
);

	typedef struct packed {
		logic [SW_W-1:0]   sw;
		logic [ST_W-1:0]   status;
		logic [ST_W-1:0]   mask;
		logic [CNT_W-1:0]  count;
		logic              neg_s1;
		logic              neg_s2;
		logic              pos_s1;
		logic              pos_s2;
		logic              btn_s1;
		logic              btn_s2;
		logic              trig_prev;
		logic [DATA_W-1:0] rdata;
	} tstc_state_t;

	tstc_state_t st;
	tstc_state_t next_st;
	tstc_mode_t  mode;
	logic        trig;
	logic        trig_rise;
	logic        clr;
	logic        sw_wr;
	logic        tick;
	logic        inc;
	logic        zero;
	logic        wrap;

	////////////////////////////////////////////////////////////////////
	// trigger and time base

	// pins are read only after their second flip-flop
	assign trig = event_trigger | ~st.neg_s2 | st.pos_s2; // R15 R6 R7 R8 R9
	assign trig_rise = trig & ~st.trig_prev;
	assign mode = tstc_mode(st.sw);
	assign sw_wr = reg_wr && reg_addr == REG_SWITCH;
	// manual reset from the button or a control write
	assign clr = st.btn_s2
		| (reg_wr && reg_addr == REG_CONTROL && reg_wdata[CTRL_CLEAR_BIT]);

	// restart keeps the first tick a full period after a change
	tstc_tick_div #(
		.SLOW_CYC (DIV_W'(SLOW_TICK_CYCLES))
	) u_div (
		.ref_clk (ref_clk),
		.rst     (rst),
		.restart (sw_wr | clr),
		.decade  (tstc_decade(st.sw)), // R3 R5 R14
		.tick    (tick)
	);

	always_comb
	begin
		case (mode)
			TSTC_M_RESET: inc = ~trig & tick; // R2
			TSTC_M_GATED: inc = trig & tick;  // R1
			TSTC_M_EVENT: inc = trig_rise;    // R13
			default:      inc = 1'b0;
		endcase
	end

	// trigger level holds the count at zero in reset mode
	assign zero = clr | (mode == TSTC_M_RESET && trig); // R2 R16
	assign wrap = inc & ~zero & (&st.count); // R4

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		next_st = st;
		next_st.neg_s1 = trigger_input_n; // R16
		next_st.neg_s2 = st.neg_s1;
		next_st.pos_s1 = trigger_input;
		next_st.pos_s2 = st.pos_s1;
		next_st.btn_s1 = manual_reset;
		next_st.btn_s2 = st.btn_s1;
		next_st.trig_prev = trig;

		// plain binary count of units, wraps at full scale
		if (zero)
			next_st.count = COUNT_RST;
		else if (inc)
			next_st.count = CNT_W'(st.count + 1'b1); // R10 R1 R2 R13

		if (sw_wr)
			next_st.sw = reg_wdata[SW_W-1:0];
		if (reg_wr && reg_addr == REG_MASK)
			next_st.mask = reg_wdata[ST_W-1:0];

		// clears first, so a same-cycle event survives
		if (reg_wr && reg_addr == REG_STATUS)
			next_st.status = st.status & ~reg_wdata[ST_W-1:0];
		if (clr)
			next_st.status[ST_OVF_BIT] = 1'b0; // R16
		if (wrap)
			next_st.status[ST_OVF_BIT] = 1'b1; // R4
		if (trig_rise)
			next_st.status[ST_TRIG_BIT] = 1'b1;

		next_st.rdata = '0;
		if (reg_rd)
		begin
			case (reg_addr)
				REG_SWITCH: next_st.rdata = DATA_W'(st.sw);
				REG_COUNT:  next_st.rdata = DATA_W'(st.count);
				REG_STATUS: next_st.rdata = DATA_W'(st.status);
				REG_MASK:   next_st.rdata = DATA_W'(st.mask);
				default:    next_st.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st <= '0;
			st.sw <= SWITCH_RST;
			st.status <= STATUS_RST;
			st.mask <= MASK_RST;
			st.count <= COUNT_RST;
			// idle pins: low-active line high, high-active line low
			st.neg_s1 <= 1'b1;
			st.neg_s2 <= 1'b1;
		end
		else
			st <= next_st;
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign stamp_count = st.count; // R11
	assign overflow_lamp = st.status[ST_OVF_BIT]; // R4
	assign irq = |(st.status & st.mask);
	assign reg_rdata = st.rdata;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_gate_hold: assert property ( // R1
		mode == TSTC_M_GATED && !trig && !clr
		|=> stamp_count == $past(stamp_count))
		else $error("gated count moved without trigger");

	a_gate_count: assert property ( // R1
		mode == TSTC_M_GATED && trig && tick && !clr
		|=> stamp_count == CNT_W'($past(stamp_count) + 1'b1))
		else $error("gated count missed a tick");

	a_reset_zero: assert property ( // R2
		mode == TSTC_M_RESET && trig |=> stamp_count == COUNT_RST)
		else $error("trigger did not zero the count");

	a_free_count: assert property ( // R2
		mode == TSTC_M_RESET && !trig && tick && !clr
		|=> stamp_count == CNT_W'($past(stamp_count) + 1'b1))
		else $error("free count missed a tick");

	a_edge_count: assert property ( // R13
		mode == TSTC_M_EVENT && !clr && trig ##1 trig && !clr
		|=> stamp_count == $past(stamp_count))
		else $error("held trigger counted more than once");

	a_edge_step: assert property ( // R13
		mode == TSTC_M_EVENT && trig_rise && !clr
		|=> stamp_count == CNT_W'($past(stamp_count) + 1'b1))
		else $error("trigger edge not counted");

	a_ovf_lamp: assert property ( // R4
		wrap |=> overflow_lamp && stamp_count == COUNT_RST)
		else $error("wrap did not light the lamp");

	a_clear_all: assert property ( // R16
		clr |=> stamp_count == COUNT_RST && !overflow_lamp)
		else $error("manual reset left count or overflow");

	a_low_pin: assert property ( // R7
		(!trigger_input_n)[*3] |-> trig)
		else $error("low-active pin not seen as trigger");

	a_high_pin: assert property ( // R8
		(trigger_input)[*3] |-> trig)
		else $error("high-active pin not seen as trigger");

	a_trig_idle: assert property ( // R15
		(!event_trigger && trigger_input_n && !trigger_input)[*3]
		|-> !trig)
		else $error("trigger asserted with all sources idle");

	////////////////////////////////////////////////////////////////////
	// time base, synchronisers, flags and read-back

	a_lamp_sticky: assert property ( // R4
		overflow_lamp && !clr && !(reg_wr && reg_addr == REG_STATUS
		&& reg_wdata[ST_OVF_BIT]) |=> overflow_lamp)
		else $error("overflow lamp dropped without a clear");

	a_lamp_rise: assert property ( // R4
		!$past(rst) && $rose(overflow_lamp) |-> $past(wrap))
		else $error("overflow lamp lit without a wrap");

	a_gate_base: assert property ( // R1
		mode == TSTC_M_GATED && !tick && !clr |=> $stable(stamp_count))
		else $error("gated count moved between ticks");

	a_reset_base: assert property ( // R2
		mode == TSTC_M_RESET && !tick && !trig && !clr
		|=> $stable(stamp_count))
		else $error("free count moved between ticks");

	a_reset_held: assert property ( // R2
		mode == TSTC_M_RESET && trig ##1 trig |-> stamp_count == COUNT_RST)
		else $error("count left zero while trigger held");

	a_event_base: assert property ( // R13
		mode == TSTC_M_EVENT && !trig_rise && !clr
		|=> $stable(stamp_count))
		else $error("edge count moved without a trigger edge");

	a_event_direct: assert property ( // R9
		event_trigger |-> trig)
		else $error("event trigger not seen at once");

	a_low_direct: assert property ( // R7
		!st.neg_s2 |-> trig)
		else $error("synced low-active pin not seen as trigger");

	a_high_direct: assert property ( // R8
		st.pos_s2 |-> trig)
		else $error("synced high-active pin not seen as trigger");

	a_sync_low: assert property ( // R16
		!$past(rst) && !$past(rst, 2)
		|-> st.neg_s2 == $past(trigger_input_n, 2))
		else $error("low-active pin not synchronised in two stages");

	a_sync_high: assert property ( // R16
		!$past(rst) && !$past(rst, 2)
		|-> st.pos_s2 == $past(trigger_input, 2))
		else $error("high-active pin not synchronised in two stages");

	a_sync_button: assert property ( // R16
		!$past(rst) && !$past(rst, 2)
		|-> st.btn_s2 == $past(manual_reset, 2))
		else $error("reset button not synchronised in two stages");

	a_slow_base: assert property ( // R3
		st.sw == SW_GATED_HI && tick && !sw_wr && !clr |=> !tick)
		else $error("slowest gated base ticks too often");

	a_tenth_base: assert property ( // R5
		st.sw == SW_GATED_LO |-> tick)
		else $error("0.1 us base missed a tick");

	a_count_step: assert property ( // R10
		!$past(rst) && !$past(zero) && stamp_count != $past(stamp_count)
		|-> stamp_count == CNT_W'($past(stamp_count) + 1'b1))
		else $error("count moved by other than one unit");

	a_rd_count: assert property ( // R11
		reg_rd && reg_addr == REG_COUNT
		|=> reg_rdata == DATA_W'($past(stamp_count)))
		else $error("count read back wrong");

	a_rdata_idle: assert property ( // R11
		!reg_rd |=> reg_rdata == '0)
		else $error("read data shown without a read");

	a_irq_lamp: assert property ( // R4
		overflow_lamp && st.mask[ST_OVF_BIT] |-> irq)
		else $error("unmasked overflow gave no interrupt");

	a_edge_status: assert property ( // R13
		trig_rise |=> st.status[ST_TRIG_BIT])
		else $error("trigger edge not flagged in status");

endmodule

//--- verification/tstc_trig_model.sv
`timescale 1ns/1ps
module tstc_trig_model
(
	input  wire logic ref_clk,         // counting clock
	input  wire logic want_evt,        // bench asks for an event match
	input  wire logic want_lo,         // bench pulls the low-active line low
	input  wire logic want_hi,         // bench raises the high-active line
	input  wire logic slow,            // event-match answer one cycle later
	output logic      event_trigger,   // event-match trigger
	output logic      trigger_input_n, // target interrupt, low active
	output logic      trigger_input    // target interrupt, high active
);
	logic [1:0] evt_q = 2'h0;
	logic       lo_q  = 1'h0;
	logic       hi_q  = 1'h0;

	always_ff @(posedge ref_clk)
	begin
		evt_q <= {evt_q[0], want_evt};
		lo_q  <= want_lo;
		hi_q  <= want_hi;
	end

	// slow answer mimics the extra delay of the matching logic
	assign event_trigger   = slow ? evt_q[1] : evt_q[0];
	assign trigger_input_n = ~lo_q;
	assign trigger_input   = hi_q;
endmodule

//--- verification/trace_time_stamp_counter_test.sv
`timescale 1ns/1ps
module trace_time_stamp_counter_test
	import tstc_pkg::*;
;
	logic              ref_clk = 1'h0;
	logic              rst = 1'h1;
	logic [ADDR_W-1:0] reg_addr = 4'h0;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic              reg_wr = 1'h0;
	logic              reg_rd = 1'h0;
	logic              manual_reset = 1'h0;
	logic              want_evt = 1'h0;
	logic              want_lo = 1'h0;
	logic              want_hi = 1'h0;
	logic              slow = 1'h0;
	logic [DATA_W-1:0] reg_rdata;
	logic              event_trigger;
	logic              trigger_input_n;
	logic              trigger_input;
	logic [CNT_W-1:0]  stamp_count;
	logic              overflow_lamp;
	logic              irq;
	int                fails = 0;
	int                n_compared = 0;

	tstc_top #(.SLOW_TICK_CYCLES(20)) u_dut (
		.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .event_trigger(event_trigger),
		.trigger_input_n(trigger_input_n), .trigger_input(trigger_input),
		.manual_reset(manual_reset), .stamp_count(stamp_count),
		.overflow_lamp(overflow_lamp), .irq(irq));

	tstc_trig_model u_far (
		.ref_clk(ref_clk), .want_evt(want_evt), .want_lo(want_lo),
		.want_hi(want_hi), .slow(slow), .event_trigger(event_trigger),
		.trigger_input_n(trigger_input_n), .trigger_input(trigger_input));

	initial
	begin
		forever #50 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		#1 check("reg_rdata", reg_rdata, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// count gained over n cycles, phase of the tick does not matter
	task automatic gain(input int n, input logic [15:0] exp);
		logic [15:0] c0;
		c0 = stamp_count;
		cyc(n);
		check("count gain", {16'h0, 16'(stamp_count - c0)}, {16'h0, exp});
	endtask

	task automatic setsw(input logic [3:0] sw);
		wr(REG_SWITCH, {28'h0, sw});
		wr(REG_CONTROL, 32'h1);
		cyc(3);
	endtask

	// which far-side line or button drive() moves
	localparam int P_EVT = 0;
	localparam int P_LO  = 1;
	localparam int P_HI  = 2;
	localparam int P_BTN = 3;

	task automatic drive(input int sel, input logic v);
		@(posedge ref_clk);
		case (sel)
			P_EVT:   want_evt <= v;
			P_LO:    want_lo <= v;
			P_HI:    want_hi <= v;
			default: manual_reset <= v;
		endcase
		cyc(5);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_mode();
		rd(REG_SWITCH, 32'h0);
		rd(REG_MASK, 32'h0);
		rd(4'hf, 32'h0);
		setsw(4'h0);
		gain(10, 16'ha);
		drive(P_EVT, 1'h1);
		check("count", {16'h0, stamp_count}, 32'h0);
		gain(5, 16'h0);
		drive(P_EVT, 1'h0);
		gain(10, 16'ha);
		setsw(4'h2);
		gain(200, 16'h2);
		setsw(4'h3);
		gain(1000, 16'h1);
	endtask

	task automatic t_time_base();
		setsw(4'h1);
		cyc(12);
		gain(100, 16'ha);
		setsw(4'h5);
		drive(P_HI, 1'h1);
		gain(20, 16'h14);
		drive(P_HI, 1'h0);
		gain(20, 16'h0);
		drive(P_LO, 1'h1);
		gain(20, 16'h14);
		drive(P_LO, 1'h0);
		setsw(4'h9);
		drive(P_EVT, 1'h1);
		cyc(20);
		gain(200, 16'ha);
		setsw(4'hb);
		gain(50, 16'h0);
		drive(P_EVT, 1'h0);
	endtask

	task automatic t_accumulate();
		wr(REG_SWITCH, 32'h5);
		drive(P_BTN, 1'h1);
		drive(P_BTN, 1'h0);
		check("count", {16'h0, stamp_count}, 32'h0);
		@(posedge ref_clk);
		want_evt <= 1'h1;
		repeat (7) @(posedge ref_clk);
		want_evt <= 1'h0;
		cyc(4);
		check("count", {16'h0, stamp_count}, 32'h7);
		rd(REG_COUNT, 32'h7);
	endtask

	task automatic t_event_count();
		setsw(4'hf);
		slow <= 1'h1;
		for (int i = 0; i < 3; i++)
		begin
			drive(P_EVT, 1'h1);
			drive(P_EVT, 1'h0);
		end
		check("count", {16'h0, stamp_count}, 32'h3);
		check("irq", {31'h0, irq}, 32'h0);
		wr(REG_MASK, 32'h2);
		check("irq", {31'h0, irq}, 32'h1);
		rd(REG_STATUS, 32'h2);
		wr(REG_STATUS, 32'h2);
		check("irq", {31'h0, irq}, 32'h0);
		slow <= 1'h0;
	endtask

	task automatic t_overflow();
		setsw(4'h0);
		check("lamp", {31'h0, overflow_lamp}, 32'h0);
		for (int i = 0; i < 70000 && overflow_lamp !== 1'h1; i++)
			cyc(1);
		check("lamp", {31'h0, overflow_lamp}, 32'h1);
		rd(REG_STATUS, 32'h1);
		wr(REG_MASK, 32'h1);
		check("irq", {31'h0, irq}, 32'h1);
		drive(P_BTN, 1'h1);
		drive(P_BTN, 1'h0);
		check("lamp", {31'h0, overflow_lamp}, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compared %0d, failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		t_reset_mode();
		t_time_base();
		t_accumulate();
		t_event_count();
		t_overflow();
		stop_test();
	end

	// the wrap wait dominates the run, well under this span
	initial
	begin
		#(100000 * 100);
		fails++;
		stop_test();
	end
endmodule
